// ---- design/sensor_pkg.sv ----
// shared constants, types and register map of the temperature readout block
package sensor_pkg;
	// command bytes
	localparam logic [7:0] CMD_MAIN_CONFIG   = 8'h03;
	localparam logic [7:0] CMD_CONV_INTERVAL = 8'h04;
	localparam logic [7:0] CMD_CHANNEL_ON    = 8'h05;
	localparam logic [7:0] CMD_FILTER        = 8'h06;
	localparam logic [7:0] CMD_ONE_SHOT      = 8'h0F;
	localparam logic [7:0] CMD_R1_HIGH_U     = 8'h19;
	localparam logic [7:0] CMD_R2_HIGH_U     = 8'h1A;
	localparam logic [7:0] CMD_R1_LOW_U      = 8'h29;
	localparam logic [7:0] CMD_R2_LOW_U      = 8'h2A;
	localparam logic [7:0] CMD_MODEL_SEL     = 8'h30;
	localparam logic [7:0] CMD_R1_OFFSET     = 8'h31;
	localparam logic [7:0] CMD_R2_OFFSET     = 8'h32;
	// field positions
	localparam int SLEEP_BIT     = 6;
	localparam int R1_MODEL_BIT  = 1;
	localparam int R2_MODEL_BIT  = 2;
	localparam int R1_FILTER_LSB = 0;
	localparam int R2_FILTER_LSB = 2;
	localparam int FRAC_BITS     = 5;
	// reset values
	localparam logic       RST_SLEEP   = 1'b0;
	localparam logic [1:0] RST_RATE    = 2'h2;
	localparam logic [1:0] RST_MODEL   = 2'h1;
	localparam logic [7:0] RST_OFFSET  = 8'h00;
	localparam logic [1:0] RST_FILTER  = 2'h3;
	localparam logic [2:0] RST_CHAN_ON = 3'h7;
	// rate codes and filter codes
	localparam logic [1:0] RATE_CONTINUOUS = 2'h0;
	localparam logic [1:0] RATE_364MS      = 2'h1;
	localparam logic [1:0] RATE_1S         = 2'h2;
	localparam logic [1:0] FILTER_OFF      = 2'h0;
	// timing
	localparam int MCLK_KHZ         = 125000;
	localparam int INTERVAL_364_MS  = 364;
	localparam int INTERVAL_1000_MS = 1000;
	localparam int INTERVAL_2500_MS = 2500;
	localparam int INTERVAL_364_CYC  = INTERVAL_364_MS * MCLK_KHZ;
	localparam int INTERVAL_1000_CYC = INTERVAL_1000_MS * MCLK_KHZ;
	localparam int INTERVAL_2500_CYC = INTERVAL_2500_MS * MCLK_KHZ;
	localparam logic [1:0] LAST_CHAN = 2'h3;

	typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_WAIT, ST_HOLD} conv_state_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] cmd;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic       start;
		logic [1:0] channel;
		logic       beta_comp;
		logic [1:0] filter_code;
	} adc_req_t;

	typedef struct packed {
		logic              software_sleep_bit;
		logic [1:0]        rate_select_field;
		logic              remote_one_beta_comp_sel;
		logic              remote_two_beta_comp_sel;
		logic [7:0]        remote_one_offset;
		logic [7:0]        remote_two_offset;
		logic [1:0]        remote_one_filter_code;
		logic [1:0]        remote_two_filter_code;
		logic              local_channel_on;
		logic              remote_one_channel_on;
		logic              remote_two_channel_on;
		conv_state_t       state;
		logic [1:0]        chan;
		logic [31:0]       elapsed;
		logic              one_shot_pending;
		adc_req_t          adc;
		logic              busy;
		logic              rd_pend;
		logic [7:0]        rd_cmd;
		logic [7:0]        rd_data;
		logic              rd_valid;
	} ctl_t;
endpackage : sensor_pkg

// ---- design/result_store.sv ----
// two-word store of corrected remote results with registered read
`timescale 1ns/1ps
module result_store
	import sensor_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_sync_b,
	// write side
	input  wire logic        we,
	input  wire logic        waddr,
	input  wire logic [12:0] wdata,
	// read side
	input  wire logic        raddr,
	output logic      [12:0] rdata_q
);
	typedef struct packed {
		logic [1:0][12:0] word;
		logic [12:0]      rdata;
	} store_t;

	store_t s_q;
	store_t s_d;

	always_comb begin
		s_d = s_q;
		for (int i = 0; i < 2; i++) begin
			if (we && (waddr == i[0])) begin
				s_d.word[i] = wdata;
			end
		end
		s_d.rdata = s_q.word[raddr];
	end

	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_q = s_q.rdata;
endmodule : result_store

// ---- design/temp_readout.sv ----
// register control, conversion sequencing and remote result formatting
`timescale 1ns/1ps
module temp_readout
	import sensor_pkg::*;
#(
	parameter int unsigned INTERVAL_364_CYCLES  = INTERVAL_364_CYC,
	parameter int unsigned INTERVAL_1000_CYCLES = INTERVAL_1000_CYC,
	parameter int unsigned INTERVAL_2500_CYCLES = INTERVAL_2500_CYC
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// command-byte register port from the bus engine
	input  wire reg_req_t    reg_req,
	output logic      [7:0]  rd_data_q,
	output logic             rd_valid_q,
	// converter
	output adc_req_t         adc_req_q,
	input  wire logic        adc_done,
	input  wire logic [12:0] adc_result,
	// status
	output logic             conv_busy_q
);
	logic        rst_meta_q;
	logic        rst_sync_q;
	ctl_t        c_q;
	ctl_t        c_d;
	logic        store_we;
	logic        store_waddr;
	logic [12:0] store_wdata;
	logic        store_raddr;
	logic [12:0] store_rdata;
	logic [14:0] sum;
	logic [12:0] corrected;
	logic [7:0]  offset_sel;
	logic [1:0]  filter_sel;
	logic [2:0]  chan_on;
	logic [31:0] interval;
	logic [7:0]  rd_value;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	result_store u_store (
		.mclk       (mclk),
		.rst_sync_b (rst_sync_q),
		.we         (store_we),
		.waddr      (store_waddr),
		.wdata      (store_wdata),
		.raddr      (store_raddr),
		.rdata_q    (store_rdata)
	);

	assign store_raddr = reg_req.cmd[1];

	always_comb begin
		chan_on    = {c_q.remote_two_channel_on, c_q.remote_one_channel_on, c_q.local_channel_on};
		offset_sel = (c_q.chan == 2'h2) ? c_q.remote_two_offset : c_q.remote_one_offset;
		filter_sel = (c_q.chan == 2'h2) ? c_q.remote_two_filter_code : c_q.remote_one_filter_code;
		// sign-extended offset scaled from half to 1/32 degree
		sum = {2'b00, adc_result} + {{3{offset_sel[7]}}, offset_sel, 4'h0};
		// clamp keeps the unsigned range instead of wrapping
		if (sum[14]) begin
			corrected = '0;
		end else if (sum[13]) begin
			corrected = '1;
		end else begin
			corrected = sum[12:0];
		end
		if (filter_sel == FILTER_OFF) begin
			corrected[1:0] = 2'b00;
		end
		store_wdata = corrected;
		store_waddr = c_q.chan[1];
		store_we    = (c_q.state == ST_WAIT) && adc_done && (c_q.chan != 2'h0);
		case (c_q.rate_select_field)
			RATE_364MS: interval = INTERVAL_364_CYCLES;
			RATE_1S:    interval = INTERVAL_1000_CYCLES;
			default:    interval = INTERVAL_2500_CYCLES;
		endcase
	end

	always_comb begin
		rd_value = 8'h00;
		case (c_q.rd_cmd)
			CMD_MAIN_CONFIG:   rd_value[SLEEP_BIT] = c_q.software_sleep_bit;
			CMD_CONV_INTERVAL: rd_value[1:0] = c_q.rate_select_field;
			CMD_CHANNEL_ON:    rd_value[2:0] = chan_on;
			CMD_FILTER:        rd_value[3:0] = {c_q.remote_two_filter_code,
			                                    c_q.remote_one_filter_code};
			CMD_MODEL_SEL: begin
				rd_value[R1_MODEL_BIT] = c_q.remote_one_beta_comp_sel;
				rd_value[R2_MODEL_BIT] = c_q.remote_two_beta_comp_sel;
			end
			CMD_R1_OFFSET:     rd_value = c_q.remote_one_offset;
			CMD_R2_OFFSET:     rd_value = c_q.remote_two_offset;
			CMD_R1_HIGH_U, CMD_R2_HIGH_U: rd_value = store_rdata[12:FRAC_BITS];
			CMD_R1_LOW_U, CMD_R2_LOW_U:   rd_value = {store_rdata[4:0], 3'b000};
			default:           rd_value = 8'h00;
		endcase
	end

	always_comb begin
		c_d              = c_q;
		c_d.adc.start    = 1'b0;
		c_d.rd_valid     = c_q.rd_pend;
		c_d.rd_data      = c_q.rd_pend ? rd_value : c_q.rd_data;
		c_d.rd_pend      = reg_req.rd;
		c_d.rd_cmd       = reg_req.rd ? reg_req.cmd : c_q.rd_cmd;
		c_d.elapsed      = c_q.elapsed + 32'h1;
		if (reg_req.wr) begin
			case (reg_req.cmd)
				CMD_MAIN_CONFIG:   c_d.software_sleep_bit = reg_req.wdata[SLEEP_BIT];
				CMD_CONV_INTERVAL: c_d.rate_select_field = reg_req.wdata[1:0];
				CMD_CHANNEL_ON: begin
					c_d.local_channel_on      = reg_req.wdata[0];
					c_d.remote_one_channel_on = reg_req.wdata[1];
					c_d.remote_two_channel_on = reg_req.wdata[2];
				end
				CMD_FILTER: begin
					c_d.remote_one_filter_code = reg_req.wdata[R1_FILTER_LSB +: 2];
					c_d.remote_two_filter_code = reg_req.wdata[R2_FILTER_LSB +: 2];
				end
				CMD_MODEL_SEL: begin
					c_d.remote_one_beta_comp_sel = reg_req.wdata[R1_MODEL_BIT];
					c_d.remote_two_beta_comp_sel = reg_req.wdata[R2_MODEL_BIT];
				end
				CMD_R1_OFFSET:     c_d.remote_one_offset = reg_req.wdata;
				CMD_R2_OFFSET:     c_d.remote_two_offset = reg_req.wdata;
				default: ;
			endcase
		end
		case (c_q.state)
			ST_IDLE: begin
				c_d.busy = 1'b0;
				if (!c_q.software_sleep_bit || c_q.one_shot_pending) begin
					c_d.one_shot_pending = 1'b0;
					c_d.state   = ST_SCAN;
					c_d.chan    = 2'h0;
					c_d.elapsed = 32'h0;
					c_d.busy    = 1'b1;
				end
			end
			ST_SCAN: begin
				if (c_q.chan == LAST_CHAN) begin
					c_d.busy = 1'b0;
					if (c_q.software_sleep_bit) begin
						c_d.state = ST_IDLE;
					end else if (c_q.rate_select_field == RATE_CONTINUOUS) begin
						c_d.state   = ST_SCAN;
						c_d.chan    = 2'h0;
						c_d.elapsed = 32'h0;
						c_d.busy    = 1'b1;
					end else begin
						c_d.state = ST_HOLD;
					end
				end else if (chan_on[c_q.chan]) begin
					c_d.adc.start       = 1'b1;
					c_d.adc.channel     = c_q.chan;
					c_d.adc.beta_comp   = (c_q.chan == 2'h2) ? c_q.remote_two_beta_comp_sel
					                                         : c_q.remote_one_beta_comp_sel;
					c_d.adc.filter_code = (c_q.chan == 2'h0) ? FILTER_OFF : filter_sel;
					c_d.state           = ST_WAIT;
				end else begin
					c_d.chan = c_q.chan + 2'h1;
				end
			end
			ST_WAIT: begin
				if (adc_done) begin
					c_d.chan  = c_q.chan + 2'h1;
					c_d.state = ST_SCAN;
				end
			end
			ST_HOLD: begin
				if (c_q.software_sleep_bit) begin
					c_d.state = ST_IDLE;
				end else if (c_q.elapsed >= interval - 32'h1) begin
					c_d.state   = ST_SCAN;
					c_d.chan    = 2'h0;
					c_d.elapsed = 32'h0;
					c_d.busy    = 1'b1;
				end
			end
			default: c_d.state = ST_IDLE;
		endcase
		// data is ignored; a trigger landing as a sequence starts still counts
		if (reg_req.wr && (reg_req.cmd == CMD_ONE_SHOT) && c_q.software_sleep_bit) begin
			c_d.one_shot_pending = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			c_q                          <= '0;
			c_q.software_sleep_bit       <= RST_SLEEP;
			c_q.rate_select_field        <= RST_RATE;
			c_q.remote_one_beta_comp_sel <= RST_MODEL[0];
			c_q.remote_two_beta_comp_sel <= RST_MODEL[1];
			c_q.remote_one_offset        <= RST_OFFSET;
			c_q.remote_two_offset        <= RST_OFFSET;
			c_q.remote_one_filter_code   <= RST_FILTER;
			c_q.remote_two_filter_code   <= RST_FILTER;
			c_q.local_channel_on         <= RST_CHAN_ON[0];
			c_q.remote_one_channel_on    <= RST_CHAN_ON[1];
			c_q.remote_two_channel_on    <= RST_CHAN_ON[2];
			c_q.state                    <= ST_IDLE;
		end else begin
			c_q <= c_d;
		end
	end

	assign rd_data_q   = c_q.rd_data;
	assign rd_valid_q  = c_q.rd_valid;
	assign adc_req_q   = c_q.adc;
	assign conv_busy_q = c_q.busy;
endmodule : temp_readout

// ---- dv/temp_readout_asserts.sv ----
// property checker for the temperature readout block
`timescale 1ns/1ps
module temp_readout_asserts
	import sensor_pkg::*;
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst_b,
	// register port
	input wire reg_req_t    reg_req,
	input wire logic [7:0]  rd_data_q,
	input wire logic        rd_valid_q,
	// converter and status
	input wire adc_req_t    adc_req_q,
	input wire logic        adc_done,
	input wire logic [12:0] adc_result,
	input wire logic        conv_busy_q
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	sequence s_rd(logic [7:0] c);
		reg_req.rd && reg_req.cmd == c ##2 rd_valid_q;
	endsequence
	property p_rd_lat; reg_req.rd |-> ##2 rd_valid_q; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_one_shot; s_rd(CMD_ONE_SHOT) |-> rd_data_q == 8'h00; endproperty
	a_one_shot: assert property (p_one_shot) else $error("one-shot read not zero");
	property p_model; s_rd(CMD_MODEL_SEL) |-> (rd_data_q & 8'hF9) == 8'h00; endproperty
	a_model: assert property (p_model) else $error("model reserved bits set");
	property p_cfg; s_rd(CMD_MAIN_CONFIG) |-> (rd_data_q & 8'hBF) == 8'h00; endproperty
	a_cfg: assert property (p_cfg) else $error("config reserved bits set");
	property p_rate; s_rd(CMD_CONV_INTERVAL) |-> rd_data_q[7:2] == 6'h00; endproperty
	a_rate: assert property (p_rate) else $error("rate reserved bits set");
	property p_low; s_rd(CMD_R1_LOW_U) or s_rd(CMD_R2_LOW_U) |-> rd_data_q[2:0] == 3'h0;
	endproperty
	a_low: assert property (p_low) else $error("low byte reserved bits set");
	property p_pulse; adc_req_q.start |=> !adc_req_q.start; endproperty
	a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
	property p_busy; adc_req_q.start |-> conv_busy_q; endproperty
	a_busy: assert property (p_busy) else $error("start outside a sequence");
	property p_local; adc_req_q.start && adc_req_q.channel == 2'h0 |->
		adc_req_q.filter_code == FILTER_OFF; endproperty
	a_local: assert property (p_local) else $error("local channel filtered");
endmodule : temp_readout_asserts

bind temp_readout temp_readout_asserts chk (.mclk(mclk), .rst_b(rst_b), .reg_req(reg_req),
	.rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .adc_req_q(adc_req_q),
	.adc_done(adc_done), .adc_result(adc_result), .conv_busy_q(conv_busy_q));

// ---- dv/adc_model.sv ----
// converter stand-in answering each start after a fixed delay
`timescale 1ns/1ps
module adc_model
	import sensor_pkg::*;
#(
	parameter int DELAY = 5
) (
	// clock
	input  wire logic        mclk,
	// request and answer
	input  wire adc_req_t    req,
	input  wire logic [12:0] r1_raw,
	input  wire logic [12:0] r2_raw,
	output logic             done,
	output logic      [12:0] result
);
	int cnt = 0;
	initial begin
		done = 1'b0;
		result = 13'h0AAA;
	end
	// one assignment per signal per edge
	always @(negedge mclk) begin
		if (req.start) begin
			cnt <= DELAY;
			done <= 1'b0;
			result <= ~result; // stale data is not held
		end else if (cnt == 1) begin
			cnt <= 0;
			done <= 1'b1;
			result <= (req.channel == 2'h1) ? r1_raw : (req.channel == 2'h2) ? r2_raw : 13'h0C80;
		end else begin
			if (cnt > 0) cnt <= cnt - 1;
			done <= 1'b0;
			result <= ~result;
		end
	end
endmodule : adc_model

// ---- dv/tb_temp_readout.sv ----
// self-checking bench for the temperature readout block
`timescale 1ns/1ps
module tb_temp_readout
	import sensor_pkg::*;
;
	// short intervals keep the run brief
	localparam int I1 = 200;
	localparam int I2 = 400;
	localparam int I3 = 800;
	localparam logic [7:0] RC [9] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h30,
		8'h31, 8'h32, 8'h0F, 8'h7E};
	localparam logic [7:0] RV [9] = '{8'h00, 8'h02, 8'h07, 8'h0F, 8'h02,
		8'h00, 8'h00, 8'h00, 8'h00};
	logic        mclk   = 1'b0;
	logic        rst_b  = 1'b0;
	reg_req_t    req    = '0;
	logic [12:0] r1_raw = 13'h033F;
	logic [12:0] r2_raw = 13'h1FFF;
	logic        busy_d = 1'b0;
	logic [2:0]  r1_cfg = 3'h0;
	logic [2:0]  r2_cfg = 3'h0;
	logic [7:0]  rd_data_q;
	logic        rd_valid_q;
	logic        adc_done;
	logic        conv_busy_q;
	adc_req_t    adc_req_q;
	logic [12:0] adc_result;
	logic [15:0] e1;
	logic [15:0] e2;
	int          fails = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          starts = 0;
	int          rise_t = 0;
	int          gap = 0;
	int          n0;
	int          ex;
	temp_readout #(.INTERVAL_364_CYCLES(I1), .INTERVAL_1000_CYCLES(I2),
		.INTERVAL_2500_CYCLES(I3)) uut (.mclk(mclk), .rst_b(rst_b), .reg_req(req),
		.rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .adc_req_q(adc_req_q),
		.adc_done(adc_done), .adc_result(adc_result), .conv_busy_q(conv_busy_q));
	adc_model conv (.mclk(mclk), .req(adc_req_q), .r1_raw(r1_raw), .r2_raw(r2_raw),
		.done(adc_done), .result(adc_result));
	initial begin
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		busy_d <= conv_busy_q;
		if (adc_req_q.start === 1'b1) starts <= starts + 1;
		// last model and filter request seen per remote channel
		if (adc_req_q.start === 1'b1 && adc_req_q.channel == 2'h1) begin
			r1_cfg <= {adc_req_q.beta_comp, adc_req_q.filter_code};
		end
		if (adc_req_q.start === 1'b1 && adc_req_q.channel == 2'h2) begin
			r2_cfg <= {adc_req_q.beta_comp, adc_req_q.filter_code};
		end
		if (conv_busy_q === 1'b1 && busy_d === 1'b0) begin
			gap <= cyc - rise_t;
			rise_t <= cyc;
		end
	end
	task automatic tally_and_finish();
		if (fails == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	task automatic give_up();
		fails++;
		tally_and_finish();
	endtask : give_up
	task automatic chk(string nm, logic [7:0] e, logic [7:0] a);
		tests_run++;
		if (a !== e) begin
			fails++;
			$display("Error %s expected %h got %h", nm, e, a);
		end
	endtask : chk
	task automatic wr(logic [7:0] c, logic [7:0] d);
		@(negedge mclk);
		req <= '{1'b1, 1'b0, c, d};
		@(negedge mclk);
		req.wr <= 1'b0;
	endtask : wr
	task automatic rc(logic [7:0] c, logic [7:0] e);
		int n;
		@(negedge mclk);
		req <= '{1'b0, 1'b1, c, 8'h00};
		@(negedge mclk);
		req.rd <= 1'b0;
		for (n = 0; n < 4 && rd_valid_q !== 1'b1; n++) @(negedge mclk);
		if (n == 4) give_up();
		chk($sformatf("cmd %h", c), e, rd_data_q);
	endtask : rc
	task automatic wait_lvl(logic l, int lim);
		int n;
		for (n = 0; n < lim && conv_busy_q !== l; n++) @(negedge mclk);
		if (n == lim) give_up();
	endtask : wait_lvl
	// clamps like the design rather than wrapping
	function automatic logic [15:0] fmt(logic [12:0] raw, logic [7:0] off, logic [1:0] f);
		int s;
		logic [12:0] v;
		s = int'(raw) + 16 * int'(signed'(off));
		v = (s < 0) ? 13'h0000 : (s > 8191) ? 13'h1FFF : 13'(s);
		fmt = {v[12:5], v[4:0], 3'h0};
		if (f == FILTER_OFF) fmt[4:3] = 2'h0;
	endfunction : fmt
	initial begin
		repeat (12) @(negedge mclk);
		rst_b = 1'b1;
		repeat (3) @(negedge mclk);
		foreach (RC[i]) rc(RC[i], RV[i]);
		chk("r2 req cfg", 8'h03, {5'h00, r2_cfg});
		wr(CMD_MAIN_CONFIG, 8'hFF);
		rc(CMD_MAIN_CONFIG, 8'h40);
		wr(CMD_MODEL_SEL, 8'hFF);
		rc(CMD_MODEL_SEL, 8'h06);
		wr(CMD_CONV_INTERVAL, 8'hFF);
		rc(CMD_CONV_INTERVAL, 8'h03);
		wait_lvl(1'b0, 3000);
		wr(CMD_R1_OFFSET, 8'hFE);
		wr(CMD_R2_OFFSET, 8'h7F);
		rc(CMD_R1_OFFSET, 8'hFE);
		wr(CMD_FILTER, 8'hF3);
		rc(CMD_FILTER, 8'h03);
		for (int k = 0; k < 2; k++) begin
			wr(CMD_CHANNEL_ON, k ? 8'hFD : 8'h07);
			rc(CMD_CHANNEL_ON, k ? 8'h05 : 8'h07);
			n0 = starts;
			wr(CMD_ONE_SHOT, 8'h5A);
			wait_lvl(1'b1, 20);
			wait_lvl(1'b0, 300);
			chk("starts", k ? 8'h02 : 8'h03, 8'(starts - n0));
		end
		chk("r1 req cfg", 8'h07, {5'h00, r1_cfg});
		chk("r2 req cfg", 8'h04, {5'h00, r2_cfg});
		e1 = fmt(r1_raw, 8'hFE, 2'h3);
		e2 = fmt(r2_raw, 8'h7F, FILTER_OFF);
		rc(CMD_R1_HIGH_U, e1[15:8]);
		rc(CMD_R1_LOW_U, e1[7:0]);
		rc(CMD_R2_HIGH_U, e2[15:8]);
		rc(CMD_R2_LOW_U, e2[7:0]);
		wr(CMD_CHANNEL_ON, 8'h07);
		wr(CMD_MAIN_CONFIG, 8'h00);
		for (int r = 1; r < 4; r++) begin
			wr(CMD_CONV_INTERVAL, 8'(r));
			repeat (2) begin
				wait_lvl(1'b1, I3 + 50);
				wait_lvl(1'b0, 200);
			end
			wait_lvl(1'b1, I3 + 50);
			ex = (r == 1) ? I1 : (r == 2) ? I2 : I3;
			// two cycles of slack for sequencer bookkeeping
			chk("interval", 8'h01, 8'(gap >= ex && gap <= ex + 2));
		end
		// continuous rate keeps busy up with back-to-back sequences
		wr(CMD_CONV_INTERVAL, 8'h00);
		n0 = starts;
		ex = 0;
		repeat (200) begin
			@(negedge mclk);
			if (conv_busy_q !== 1'b1) ex++;
		end
		chk("continuous", 8'h01, 8'(ex == 0 && starts - n0 > 6));
		// a one-shot while active must not queue a later sequence
		wr(CMD_CONV_INTERVAL, 8'h03);
		wait_lvl(1'b0, 200);
		wr(CMD_ONE_SHOT, 8'hA5);
		wr(CMD_MAIN_CONFIG, 8'h40);
		n0 = starts;
		repeat (I3 + 50) @(negedge mclk);
		chk("ignored shot", 8'h00, 8'(starts - n0));
		tally_and_finish();
	end
endmodule : tb_temp_readout
